// File: include/rta_pkg.sv
// Package holding the register map, field layouts and shared types of the alarm and timer block.
package rta_pkg;

    // Width of the register bus.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets on the plain register port.
    localparam logic [7:0] OFF_ALARM_HOUR = 8'h00;
    localparam logic [7:0] OFF_ALARM_MINUTE = 8'h04;
    localparam logic [7:0] OFF_ALARM_YEAR = 8'h08;
    localparam logic [7:0] OFF_ALARM_MONTH = 8'h0C;
    localparam logic [7:0] OFF_ALARM_DATE = 8'h10;
    localparam logic [7:0] OFF_TIMER_SET = 8'h14;
    localparam logic [7:0] OFF_CONTROL = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFF_TIMER_COUNT = 8'h24;

    // Writable bits of each alarm register; the rest are reserved and read as zero.
    localparam logic [7:0] HOUR_MASK = 8'h3F;
    localparam logic [7:0] MINUTE_MASK = 8'h7F;
    localparam logic [7:0] YEAR_MASK = 8'hFF;
    localparam logic [7:0] MONTH_MASK = 8'h1F;
    localparam logic [7:0] DATE_MASK = 8'h3F;

    // Interval field of the timer setting register.
    localparam int TIMER_W = 18;

    // Reset values.
    localparam logic [7:0] ALARM_RESET = 8'h00;
    localparam logic [17:0] TIMER_RESET = 18'h0_0000;
    localparam logic [6:0] CONTROL_RESET = 7'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Control register bit positions.
    localparam int CTL_MINUTE_EN = 0;
    localparam int CTL_HOUR_EN = 1;
    localparam int CTL_DATE_EN = 2;
    localparam int CTL_MONTH_EN = 3;
    localparam int CTL_YEAR_EN = 4;
    localparam int CTL_TIMER_EN = 5;
    localparam int CTL_TIMER_REPEAT = 6;
    localparam int CTL_W = 7;

    // Interrupt status and mask bit positions.
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_TIMER = 1;
    localparam int IRQ_W = 2;

    // Calendar counter values, all BCD, as seen from the counting block.
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
    } rta_calendar_type;

    // Register port request carried as one group.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } rta_bus_req_type;

endpackage

// File: hdl/rta_interval_timer.sv
// Interval timer that counts half-second ticks and reports expiry once or repeatedly.
module rta_interval_timer #(
    parameter int WIDTH = 18
) (
    input wire logic i_clk, // Block clock.
    input wire logic i_rst_n, // Synchronised reset, active low.
    input wire logic i_ce, // Clock enable; state holds while low.
    input wire logic i_enable, // Timer runs while high.
    input wire logic i_repeat, // High for repeated expiry, low for one expiry.
    input wire logic [WIDTH-1:0] i_interval, // Interval in half seconds minus one.
    input wire logic i_tick, // Half-second tick.
    output logic o_expire, // One-cycle pulse on expiry.
    output logic o_running, // Timer is counting.
    output logic [WIDTH-1:0] o_count // Remaining ticks before expiry.
);

    logic done;

    // Load on enable, count ticks down, and expire on the tick that finds zero.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_running <= 1'b0;
            o_count <= '0;
            o_expire <= 1'b0;
            done <= 1'b0;
        end else if (i_ce) begin
            o_expire <= 1'b0;
            if (!i_enable) begin
                o_running <= 1'b0;
                done <= 1'b0;
            end else if (!o_running && !done) begin
                o_running <= 1'b1;
                o_count <= i_interval;
            end else if (o_running && i_tick) begin
                if (o_count == '0) begin
                    o_expire <= 1'b1;
                    if (i_repeat) begin
                        o_count <= i_interval;
                    end else begin
                        o_running <= 1'b0;
                        done <= 1'b1;
                    end
                end else begin
                    o_count <= o_count - 1'b1;
                end
            end
        end
    end

endmodule // rta_interval_timer

// File: hdl/rta_top.sv
// Alarm and interval timer setup block with register port, alarm compare and interrupt.
// What this block does
// - Alarm hour tens digit sits in bits 5:4, legal values 0 to 2.
// - Alarm hour units digit sits in bits 3:0 as BCD, 0 to 9.
// - Alarm minute tens digit sits in bits 6:4, legal values 0 to 5.
// - Alarm minute units digit sits in bits 3:0 as BCD, 0 to 9.
// - Alarm year tens digit sits in bits 7:4 as BCD, 0 to 9.
// - Alarm year units digit sits in bits 3:0 as BCD, 0 to 9.
// - Alarm month tens digit is the single bit 4.
// - Alarm month units digit sits in bits 3:0 as BCD, 0 to 9.
// - Reserved bits of alarm and timer registers read zero; software writes zero.
// - Timer setting holds an 18-bit read/write interval in bits 17:0.
// - Interval counts half seconds as twice the seconds minus one.
// - Timer expires once, or repeatedly at every interval.
// - Alarm may fire right after an enable is set; software rechecks counters.
// - Alarm date units digit sits in bits 3:0 as BCD, 0 to 9.
//
// Added by the designer: strobed register access and the address map.
module rta_top (
    input wire logic i_clk, // Block clock, 125 MHz.
    input wire logic i_nrst, // Asynchronous reset, active low.
    input wire logic i_ce, // Clock enable; all state holds while low.
    input wire logic [rta_pkg::ADDR_W-1:0] i_addr, // Register byte address.
    input wire logic [rta_pkg::DATA_W-1:0] i_wdata, // Register write data.
    input wire logic i_wr, // Write strobe.
    input wire logic i_rd, // Read strobe.
    input wire rta_pkg::rta_calendar_type i_cal, // Calendar counter values.
    input wire logic i_half_tick, // Half-second tick from the sub-second counter.
    output logic [rta_pkg::DATA_W-1:0] o_rdata, // Read data, valid the cycle after i_rd.
    output logic o_irq // Level interrupt.
);

    logic rst_meta;
    logic rst_n;
    rta_pkg::rta_bus_req_type req;
    logic [7:0] alarm_hour;
    logic [7:0] alarm_minute;
    logic [7:0] alarm_year;
    logic [7:0] alarm_month;
    logic [7:0] alarm_date;
    logic [rta_pkg::TIMER_W-1:0] timer_interval_value;
    logic [rta_pkg::CTL_W-1:0] control;
    logic [rta_pkg::IRQ_W-1:0] irq_status;
    logic [rta_pkg::IRQ_W-1:0] irq_mask;
    logic match_prev;
    logic match_now;
    logic alarm_event;
    logic timer_expire;
    logic timer_running;
    logic [rta_pkg::TIMER_W-1:0] timer_count;
    logic [rta_pkg::IRQ_W-1:0] events;
    logic [rta_pkg::IRQ_W-1:0] clear_bits;
    logic [rta_pkg::DATA_W-1:0] next_rdata;
    logic year_match_enable;
    logic month_match_enable;
    logic date_match_enable;
    logic hour_match_enable;
    logic minute_match_enable;

    // Release the reset through two flip-flops so the rest of the block leaves it cleanly.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else if (i_ce) begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Bundle the register port request.
    assign req.addr = i_addr;
    assign req.wdata = i_wdata;
    assign req.wr = i_wr & i_ce;
    assign req.rd = i_rd & i_ce;

    // Name the match enables from the control register.
    assign year_match_enable = control[rta_pkg::CTL_YEAR_EN];
    assign month_match_enable = control[rta_pkg::CTL_MONTH_EN];
    assign date_match_enable = control[rta_pkg::CTL_DATE_EN];
    assign hour_match_enable = control[rta_pkg::CTL_HOUR_EN];
    assign minute_match_enable = control[rta_pkg::CTL_MINUTE_EN];

    // Alarm setting registers; reserved bits are masked off so they always read zero.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_hour <= rta_pkg::ALARM_RESET;
            alarm_minute <= rta_pkg::ALARM_RESET;
            alarm_year <= rta_pkg::ALARM_RESET;
            alarm_month <= rta_pkg::ALARM_RESET;
            alarm_date <= rta_pkg::ALARM_RESET;
        end else if (req.wr) begin
            unique case (req.addr)
                rta_pkg::OFF_ALARM_HOUR: begin
                    alarm_hour <= req.wdata[7:0] & rta_pkg::HOUR_MASK;
                end
                rta_pkg::OFF_ALARM_MINUTE: begin
                    alarm_minute <= req.wdata[7:0] & rta_pkg::MINUTE_MASK;
                end
                rta_pkg::OFF_ALARM_YEAR: begin
                    alarm_year <= req.wdata[7:0] & rta_pkg::YEAR_MASK;
                end
                rta_pkg::OFF_ALARM_MONTH: begin
                    alarm_month <= req.wdata[7:0] & rta_pkg::MONTH_MASK;
                end
                rta_pkg::OFF_ALARM_DATE: begin
                    alarm_date <= req.wdata[7:0] & rta_pkg::DATE_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Timer setting register keeps only the interval field.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_interval_value <= rta_pkg::TIMER_RESET;
        end else if (req.wr && req.addr == rta_pkg::OFF_TIMER_SET) begin
            timer_interval_value <= req.wdata[rta_pkg::TIMER_W-1:0];
        end
    end

    // Control register: match enables, timer enable and timer repeat mode.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            control <= rta_pkg::CONTROL_RESET;
        end else if (req.wr && req.addr == rta_pkg::OFF_CONTROL) begin
            control <= req.wdata[rta_pkg::CTL_W-1:0];
        end
    end

    // Interrupt mask register.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= rta_pkg::IRQ_RESET;
        end else if (req.wr && req.addr == rta_pkg::OFF_IRQ_MASK) begin
            irq_mask <= req.wdata[rta_pkg::IRQ_W-1:0];
        end
    end

    // Compare every enabled alarm field against its counter; no enable means no match.
    always_comb begin
        match_now = (year_match_enable | month_match_enable | date_match_enable
                     | hour_match_enable | minute_match_enable)
            && (!year_match_enable || alarm_year == i_cal.year)
            && (!month_match_enable || alarm_month == i_cal.month)
            && (!date_match_enable || alarm_date == i_cal.date)
            && (!hour_match_enable || alarm_hour == i_cal.hour)
            && (!minute_match_enable || alarm_minute == i_cal.minute);
    end

    // Fire on the rising edge of the match, which also covers an enable being set.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_prev <= 1'b0;
        end else if (i_ce) begin
            match_prev <= match_now;
        end
    end

    assign alarm_event = match_now & ~match_prev;

    // Interval timer counting half-second ticks.
    rta_interval_timer #(
        .WIDTH(rta_pkg::TIMER_W)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_enable(control[rta_pkg::CTL_TIMER_EN]),
        .i_repeat(control[rta_pkg::CTL_TIMER_REPEAT]),
        .i_interval(timer_interval_value),
        .i_tick(i_half_tick),
        .o_expire(timer_expire),
        .o_running(timer_running),
        .o_count(timer_count)
    );

    // Gather events and the write-one-to-clear bits.
    always_comb begin
        events = '0;
        events[rta_pkg::IRQ_ALARM] = alarm_event;
        events[rta_pkg::IRQ_TIMER] = timer_expire;
        clear_bits = '0;
        if (req.wr && req.addr == rta_pkg::OFF_IRQ_STATUS) begin
            clear_bits = req.wdata[rta_pkg::IRQ_W-1:0];
        end
    end

    // Sticky status; a new event in the clearing cycle wins over the clear.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= rta_pkg::IRQ_RESET;
        end else if (i_ce) begin
            irq_status <= (irq_status & ~clear_bits) | events;
        end
    end

    // Interrupt level follows unmasked status bits.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= |(((irq_status & ~clear_bits) | events) & irq_mask);
        end
    end

    // Read multiplexer; unmapped addresses and reserved bits return zero.
    always_comb begin
        next_rdata = '0;
        if (req.rd) begin
            unique case (req.addr)
                rta_pkg::OFF_ALARM_HOUR: next_rdata[7:0] = alarm_hour;
                rta_pkg::OFF_ALARM_MINUTE: next_rdata[7:0] = alarm_minute;
                rta_pkg::OFF_ALARM_YEAR: next_rdata[7:0] = alarm_year;
                rta_pkg::OFF_ALARM_MONTH: next_rdata[7:0] = alarm_month;
                rta_pkg::OFF_ALARM_DATE: next_rdata[7:0] = alarm_date;
                rta_pkg::OFF_TIMER_SET: begin
                    next_rdata[rta_pkg::TIMER_W-1:0] = timer_interval_value;
                end
                rta_pkg::OFF_CONTROL: next_rdata[rta_pkg::CTL_W-1:0] = control;
                rta_pkg::OFF_IRQ_STATUS: next_rdata[rta_pkg::IRQ_W-1:0] = irq_status;
                rta_pkg::OFF_IRQ_MASK: next_rdata[rta_pkg::IRQ_W-1:0] = irq_mask;
                rta_pkg::OFF_TIMER_COUNT: begin
                    next_rdata[rta_pkg::TIMER_W-1:0] = timer_count;
                    next_rdata[rta_pkg::DATA_W-1] = timer_running;
                end
                default: next_rdata = '0;
            endcase
        end
    end

    // Read data stand for exactly the cycle after the read strobe.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            o_rdata <= next_rdata;
        end
    end

    // Hour write stores only the digit fields.
    hour_store_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (req.wr && req.addr == rta_pkg::OFF_ALARM_HOUR)
        |=> alarm_hour == ($past(i_wdata[7:0]) & 8'h3F))
        else $error("alarm hour did not store the written digits");

    // Minute write stores only the digit fields.
    minute_store_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (req.wr && req.addr == rta_pkg::OFF_ALARM_MINUTE)
        |=> alarm_minute == ($past(i_wdata[7:0]) & 8'h7F))
        else $error("alarm minute did not store the written digits");

    // Year write stores both nibbles.
    year_store_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (req.wr && req.addr == rta_pkg::OFF_ALARM_YEAR)
        |=> alarm_year == $past(i_wdata[7:0]))
        else $error("alarm year did not store the written digits");

    // Month and date writes keep their digit fields only.
    month_store_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (req.wr && req.addr == rta_pkg::OFF_ALARM_MONTH)
        |=> alarm_month == ($past(i_wdata[7:0]) & 8'h1F))
        else $error("alarm month did not store the written digits");

    date_store_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (req.wr && req.addr == rta_pkg::OFF_ALARM_DATE)
        |=> alarm_date == ($past(i_wdata[7:0]) & 8'h3F))
        else $error("alarm date did not store the written digits");

    // A read of the timer setting shows the interval and zero above it.
    timer_readback_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (req.rd && req.addr == rta_pkg::OFF_TIMER_SET && !req.wr)
        |=> o_rdata[31:18] == 14'h0000
            && o_rdata[17:0] == $past(timer_interval_value))
        else $error("timer setting read back wrong");

    // A read of the hour register leaves reserved bits at zero.
    hour_reserved_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (req.rd && req.addr == rta_pkg::OFF_ALARM_HOUR) |=> o_rdata[31:6] == 26'h0)
        else $error("reserved hour bits read non-zero");

    // A new full match raises the alarm status bit one cycle later.
    alarm_raise_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && match_now && !match_prev) |=> irq_status[rta_pkg::IRQ_ALARM])
        else $error("alarm match did not set the status bit");

    // Setting the minute enable alone, with the alarm minute already agreeing, raises the alarm at once.
    alarm_enable_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && !match_prev && $rose(minute_match_enable) && !hour_match_enable
         && !date_match_enable && !month_match_enable && !year_match_enable
         && alarm_minute == i_cal.minute)
        |=> irq_status[rta_pkg::IRQ_ALARM])
        else $error("alarm not raised after enable with matching minute");

    // A one-shot timer stops after expiry while a repeating timer keeps running.
    timer_mode_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (timer_expire && i_ce && control[rta_pkg::CTL_TIMER_EN])
        |-> (timer_running == control[rta_pkg::CTL_TIMER_REPEAT]))
        else $error("timer run state after expiry disagrees with mode");

    // A tick seen at zero count expires the timer in the next cycle.
    timer_expiry_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && timer_running && i_half_tick && timer_count == 18'h0_0000
         && control[rta_pkg::CTL_TIMER_EN])
        |=> timer_expire)
        else $error("timer did not expire on the tick at zero");

    // Minute and month reads leave their reserved bits at zero.
    minute_reserved_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (req.rd && req.addr == rta_pkg::OFF_ALARM_MINUTE) |=> o_rdata[31:7] == 25'h0)
        else $error("reserved minute bits read non-zero");

    month_reserved_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (req.rd && req.addr == rta_pkg::OFF_ALARM_MONTH) |=> o_rdata[31:5] == 27'h0)
        else $error("reserved month bits read non-zero");

    // Read data return to zero after any enabled cycle without a read strobe.
    rdata_idle_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && !i_rd) |=> o_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");

    // The interrupt level follows the unmasked status bits.
    irq_level_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_ce |=> o_irq == |(irq_status & $past(irq_mask)))
        else $error("interrupt level disagrees with masked status");

    // A set alarm status bit stays set until software writes a one to it.
    status_sticky_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (irq_status[rta_pkg::IRQ_ALARM] && !clear_bits[rta_pkg::IRQ_ALARM])
        |=> irq_status[rta_pkg::IRQ_ALARM])
        else $error("alarm status bit dropped without a clear");

    // Without a new match the alarm status bit cannot rise.
    alarm_quiet_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (!irq_status[rta_pkg::IRQ_ALARM] && !(match_now && !match_prev))
        |=> !irq_status[rta_pkg::IRQ_ALARM])
        else $error("alarm status rose without a match");

    // A low clock enable freezes the status, the interrupt and the read data.
    ce_freeze_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        !i_ce |=> $stable(irq_status) && $stable(o_irq) && $stable(o_rdata))
        else $error("state moved while the clock enable was low");

endmodule // rta_top

// File: sim/rta_top_tb.sv
// Self-checking testbench for the alarm and interval timer setup block.
module rta_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TMR_N = 3;
    logic i_clk;
    logic i_nrst;
    logic i_ce;
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    rta_pkg::rta_calendar_type i_cal;
    logic i_half_tick;
    logic [31:0] o_rdata;
    logic o_irq;
    int n_mismatch;
    int check_count;
    logic [31:0] rd_val;
    logic [31:0] wr_val;
    logic [7:0] offs [6] = '{rta_pkg::OFF_ALARM_HOUR, rta_pkg::OFF_ALARM_MINUTE,
        rta_pkg::OFF_ALARM_YEAR, rta_pkg::OFF_ALARM_MONTH, rta_pkg::OFF_ALARM_DATE,
        rta_pkg::OFF_TIMER_SET};
    logic [31:0] masks [6] = '{32'h0000_003F, 32'h0000_007F, 32'h0000_00FF,
        32'h0000_001F, 32'h0000_003F, 32'h0003_FFFF};

    rta_top dut_u (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .i_cal(i_cal),
        .i_half_tick(i_half_tick),
        .o_rdata(o_rdata),
        .o_irq(o_irq)
    );

    // Free-running 125 MHz clock shared by the register port and the counting logic.
    always #4 i_clk = ~i_clk;

    // Compares one value with its expectation and reports a difference at once.
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // One-cycle write strobe on the register port.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // One-cycle read strobe; the data are taken in the following cycle only.
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask

    // Waits long enough for a match or expiry to reach the status bit and the interrupt.
    task automatic settle();
        repeat (3) @(posedge i_clk);
        #1;
    endtask

    // One half-second tick pulse followed by time for its effect to land.
    task automatic tick();
        @(posedge i_clk);
        i_half_tick <= 1'b1;
        @(posedge i_clk);
        i_half_tick <= 1'b0;
        settle();
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #(8 * 20000);
        n_mismatch++;
        summarize();
    end

    // Main test sequence.
    initial begin
        i_clk = 1'b0;
        i_nrst = 1'b0;
        i_ce = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_half_tick = 1'b0;
        i_cal = {8'h25, 8'h11, 8'h30, 8'h23, 8'h59};
        n_mismatch = 0;
        check_count = 0;
        void'($urandom(32'hec1c));
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clk);
        // Every setting register starts at zero.
        foreach (offs[k]) begin
            rd(offs[k]);
            chk(32'h0000_0000, rd_val);
        end
        // Random words, reserved bits included, land only in the documented fields.
        foreach (offs[k]) begin
            for (int j = 0; j < 4; j++) begin
                wr_val = $urandom;
                if (k == 5) begin
                    wr_val[17:0] = 18'(wr_val % 32'd172799 + 32'd1);
                end
                wr(offs[k], wr_val);
                rd(offs[k]);
                chk(wr_val & masks[k], rd_val);
            end
        end
        // Top of the legal interval range, then the lowest one beside reserved ones.
        wr(rta_pkg::OFF_TIMER_SET, 32'h0002_A2FF);
        rd(rta_pkg::OFF_TIMER_SET);
        chk(32'h0002_A2FF, rd_val);
        wr(rta_pkg::OFF_TIMER_SET, 32'hFFFC_0001);
        rd(rta_pkg::OFF_TIMER_SET);
        chk(32'h0000_0001, rd_val);
        // An unmapped place ignores writes and reads as zero.
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40);
        chk(32'h0000_0000, rd_val);
        // A write while the clock enable is low leaves the register as it was.
        wr(rta_pkg::OFF_ALARM_HOUR, 32'h0000_0012);
        i_ce <= 1'b0;
        wr(rta_pkg::OFF_ALARM_HOUR, 32'h0000_0021);
        i_ce <= 1'b1;
        rd(rta_pkg::OFF_ALARM_HOUR);
        chk(32'h0000_0012, rd_val);
        // Alarm fields preloaded equal to the calendar; each enable alone fires at once.
        wr(rta_pkg::OFF_ALARM_MINUTE, 32'h0000_0059);
        wr(rta_pkg::OFF_ALARM_HOUR, 32'h0000_0023);
        wr(rta_pkg::OFF_ALARM_DATE, 32'h0000_0030);
        wr(rta_pkg::OFF_ALARM_MONTH, 32'h0000_0011);
        wr(rta_pkg::OFF_ALARM_YEAR, 32'h0000_0025);
        wr(rta_pkg::OFF_IRQ_MASK, 32'h0000_0001);
        for (int b = 0; b < 5; b++) begin
            wr(rta_pkg::OFF_CONTROL, 32'h0000_0000);
            wr(rta_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
            settle();
            chk(32'h0000_0000, {31'h0, o_irq});
            wr(rta_pkg::OFF_CONTROL, 32'h0000_0001 << b);
            settle();
            chk(32'h0000_0001, {31'h0, o_irq});
        end
        // A held match does not fire again after the status is cleared.
        wr(rta_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
        settle();
        chk(32'h0000_0000, {31'h0, o_irq});
        // One differing field among two enabled ones keeps the alarm quiet.
        wr(rta_pkg::OFF_CONTROL, 32'h0000_0000);
        wr(rta_pkg::OFF_ALARM_HOUR, 32'h0000_0022);
        wr(rta_pkg::OFF_CONTROL, 32'h0000_0003);
        settle();
        chk(32'h0000_0000, {31'h0, o_irq});
        @(posedge i_clk);
        i_cal.hour <= 8'h22;
        settle();
        chk(32'h0000_0001, {31'h0, o_irq});
        rd(rta_pkg::OFF_IRQ_STATUS);
        chk(32'h0000_0001, rd_val);
        // A masked event sets the status but leaves the interrupt low.
        wr(rta_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
        wr(rta_pkg::OFF_IRQ_MASK, 32'h0000_0000);
        i_cal.minute <= 8'h00;
        settle();
        @(posedge i_clk);
        i_cal.minute <= 8'h59;
        settle();
        chk(32'h0000_0000, {31'h0, o_irq});
        rd(rta_pkg::OFF_IRQ_STATUS);
        chk(32'h0000_0001, rd_val);
        // One-shot timer: expiry on tick N+1 only, then silent.
        wr(rta_pkg::OFF_CONTROL, 32'h0000_0000);
        wr(rta_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
        wr(rta_pkg::OFF_IRQ_MASK, 32'h0000_0002);
        wr(rta_pkg::OFF_TIMER_SET, TMR_N);
        wr(rta_pkg::OFF_CONTROL, 32'h0000_0001 << rta_pkg::CTL_TIMER_EN);
        repeat (2) @(posedge i_clk);
        for (int k = 1; k <= TMR_N + 1; k++) begin
            tick();
            chk({31'h0, k == TMR_N + 1}, {31'h0, o_irq});
        end
        wr(rta_pkg::OFF_IRQ_STATUS, 32'h0000_0002);
        for (int k = 1; k <= TMR_N + 1; k++) begin
            tick();
            chk(32'h0000_0000, {31'h0, o_irq});
        end
        // Repeating timer: expiry at every interval.
        wr(rta_pkg::OFF_CONTROL, 32'h0000_0000);
        wr(rta_pkg::OFF_CONTROL, 32'h0000_0060);
        repeat (2) @(posedge i_clk);
        rd(rta_pkg::OFF_TIMER_COUNT);
        chk(32'h8000_0000, rd_val & 32'h8000_0000);
        for (int r = 0; r < 2; r++) begin
            for (int k = 1; k <= TMR_N + 1; k++) begin
                tick();
                chk({31'h0, k == TMR_N + 1}, {31'h0, o_irq});
            end
            wr(rta_pkg::OFF_IRQ_STATUS, 32'h0000_0002);
        end
        summarize();
    end
endmodule // rta_top_tb
